// ---- core/gdr_pkg.sv ----
// Constants for the gate driver control register bank
`default_nettype none
package gdr_pkg;
  // ****************
  // Widths
  // ****************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int NUM_REGS = 21;
  localparam int IDX_W = 5;
  localparam int NUM_HB = 4;

  // ****************
  // Offsets
  // ****************
  localparam logic [4:0] OFS_GEN_CTRL1 = 5'h00;
  localparam logic [4:0] OFS_GEN_CTRL2 = 5'h01;
  localparam logic [4:0] OFS_DS_MON = 5'h02;
  localparam logic [4:0] OFS_CCB_ONE = 5'h04;
  localparam logic [4:0] OFS_CCB_BANKED = 5'h05;
  localparam logic [4:0] OFS_HB_MODE = 5'h06;
  localparam logic [4:0] OFS_PWM_SETUP = 5'h07;
  localparam logic [4:0] OFS_PRECHG_TIME = 5'h08;
  localparam logic [4:0] OFS_DIAG_CUR = 5'h09;
  localparam logic [4:0] OFS_CHG_STATIC = 5'h0a;
  localparam logic [4:0] OFS_CHG_PWM = 5'h0b;
  localparam logic [4:0] OFS_DISCHG_PWM = 5'h0c;
  localparam logic [4:0] OFS_MAX_CUR = 5'h0d;
  localparam logic [4:0] OFS_DELAY_ONE = 5'h0e;
  localparam logic [4:0] OFS_DELAY_THREE = 5'h10;

  // ****************
  // Storage slots
  // ****************
  localparam logic [4:0] IX_GC1 = 5'h00;
  localparam logic [4:0] IX_GC2 = 5'h01;
  localparam logic [4:0] IX_DSM = 5'h02;
  localparam logic [4:0] IX_CCB1 = 5'h03;
  localparam logic [4:0] IX_CCB_ACT = 5'h04;
  localparam logic [4:0] IX_CCB_FW = 5'h05;
  localparam logic [4:0] IX_HBM = 5'h06;
  localparam logic [4:0] IX_PWMS = 5'h07;
  localparam logic [4:0] IX_PCT = 5'h08;
  localparam logic [4:0] IX_DIAG = 5'h09;
  localparam logic [4:0] IX_STCHG = 5'h0a;
  localparam logic [4:0] IX_PCHGI = 5'h0b;
  localparam logic [4:0] IX_CHG_ACT = 5'h0c;
  localparam logic [4:0] IX_CHG_FW = 5'h0d;
  localparam logic [4:0] IX_DCHG_ACT = 5'h0e;
  localparam logic [4:0] IX_PDCHGI = 5'h0f;
  localparam logic [4:0] IX_MAX_ACT = 5'h10;
  localparam logic [4:0] IX_MAX_FW = 5'h11;
  localparam logic [4:0] IX_DLY1 = 5'h12;

  // ****************
  // Reset values, by slot
  // ****************
  localparam logic [15:0] RST_VAL [NUM_REGS] = '{
    16'h0026, 16'h4180, 16'h0249, 16'h0000, 16'h4924, 16'h4924, 16'h0000,
    16'h6420, 16'h0000, 16'hc000, 16'h0044, 16'h18c6, 16'h18c6, 16'h18c6,
    16'h1ce7, 16'h318c, 16'h4900, 16'h4900, 16'h0a0a, 16'h0a0a, 16'h0a0a};

  // ****************
  // Fields
  // ****************
  localparam int BANK_BIT = 9;
  localparam int WD_TOGGLE_BIT = 0;
  localparam logic [15:0] GC1_RO_ZERO = 16'h0050;
  localparam int AGC_LSB = 11;
  localparam logic [1:0] AGC_OFF = 2'h0;
endpackage
`default_nettype wire

// ---- core/gdr_regbank.sv ----
// Banked control register file of the four half-bridge gate driver
//
// Notes on behaviour
// - Offset 0x0a is the static charge current in bank 0 and the precharge init current in bank 1.
// - Offset 0x0b holds the active and the freewheeling PWM charge current, both reset 0x18c6.
// - Offset 0x0c is the active PWM discharge current in bank 0 and the predischarge init in bank 1.
// - Offset 0x0d holds active and freewheeling max current and blanking copies, both reset 0x4900.
// - Offset 0x05 holds active and freewheeling cross-current guard copies, both reset 0x4924.
// - The active max precharge setting is the gate current used in the post-discharge phase.
// - Offsets 0x0e to 0x10 are the three channel switch delays, in both banks, reset 0x0a0a.
// - Offsets 0x00 and 0x01 ignore the bank and reset to 0x0026 and 0x4180.
// - Offsets 0x02 and 0x04 ignore the bank and reset to 0x0249 and 0x0000.
// - Offset 0x07 is the PWM channel setup in bank 0 only, reset 0x6420.
// - Offset 0x08 is the precharge time register in both banks, reset 0x0000.
// - Offset 0x09 is the diagnostic current control in both banks, reset 0xc000.
// - Which MOSFET counts as active or freewheeling follows the adaptive gate control setting.
// - Bit 9 of general control one selects the bank, 0 active and static, 1 freewheel and init.
`default_nettype none
module gdr_regbank (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Register access port
  input wire logic i_acc_en,
  input wire logic i_acc_wr,
  input wire logic [gdr_pkg::ADDR_W-1:0] i_acc_addr,
  input wire logic [gdr_pkg::DATA_W-1:0] i_acc_wdata,
  output logic [gdr_pkg::DATA_W-1:0] o_acc_rdata,
  output logic o_acc_rvalid,
  output logic o_acc_err,
  // Bridge switching state
  input wire logic [gdr_pkg::NUM_HB-1:0] i_hs_switching,
  // Settings to the gate drivers
  output logic o_bank_sel,
  output logic o_failsafe,
  output logic [gdr_pkg::DATA_W-1:0] o_gen_ctrl1,
  output logic [gdr_pkg::DATA_W-1:0] o_gen_ctrl2,
  output logic [gdr_pkg::DATA_W-1:0] o_hb_mode,
  output logic [gdr_pkg::DATA_W-1:0] o_pwm_setup,
  output logic [gdr_pkg::DATA_W-1:0] o_ccb_active,
  output logic [gdr_pkg::DATA_W-1:0] o_ccb_freewheel,
  output logic [gdr_pkg::DATA_W-1:0] o_chg_active,
  output logic [gdr_pkg::DATA_W-1:0] o_chg_freewheel,
  output logic [gdr_pkg::DATA_W-1:0] o_max_active,
  output logic [gdr_pkg::DATA_W-1:0] o_max_freewheel,
  output logic [gdr_pkg::DATA_W-1:0] o_post_dischg_cur,
  output logic [gdr_pkg::NUM_HB-1:0] o_hs_uses_fw,
  output logic [gdr_pkg::NUM_HB-1:0] o_ls_uses_fw
);
  import gdr_pkg::*;

  // ****************
  // Storage
  // ****************
  logic [DATA_W-1:0] regs_ff [NUM_REGS];
  logic [DATA_W-1:0] rdata_ff;
  logic rvalid_ff;
  logic err_ff;
  logic failsafe_ff;
  logic bank;
  logic hit;
  logic [IDX_W-1:0] idx;
  logic wr_hit;
  logic [1:0] adaptive_gate_control_cfg;

  // ****************
  // Address decode
  // ****************
  // Returns {mapped, slot}; the bank decides which copy a shared offset means
  function automatic logic [IDX_W:0] decode(input logic [ADDR_W-1:0] a, input logic b);
    logic [IDX_W:0] r;
    r = {1'b0, {IDX_W{1'b0}}};
    case (a)
      OFS_GEN_CTRL1: r = {1'b1, IX_GC1};
      OFS_GEN_CTRL2: r = {1'b1, IX_GC2};
      OFS_DS_MON: r = {1'b1, IX_DSM};
      OFS_CCB_ONE: r = {1'b1, IX_CCB1};
      OFS_CCB_BANKED: r = {1'b1, b ? IX_CCB_FW : IX_CCB_ACT};
      OFS_HB_MODE: r = {1'b1, IX_HBM};
      OFS_PWM_SETUP: r = {!b, IX_PWMS};
      OFS_PRECHG_TIME: r = {1'b1, IX_PCT};
      OFS_DIAG_CUR: r = {1'b1, IX_DIAG};
      OFS_CHG_STATIC: r = {1'b1, b ? IX_PCHGI : IX_STCHG};
      OFS_CHG_PWM: r = {1'b1, b ? IX_CHG_FW : IX_CHG_ACT};
      OFS_DISCHG_PWM: r = {1'b1, b ? IX_PDCHGI : IX_DCHG_ACT};
      OFS_MAX_CUR: r = {1'b1, b ? IX_MAX_FW : IX_MAX_ACT};
      default: begin
        // Delay registers sit on consecutive offsets in either bank
        if (a >= OFS_DELAY_ONE && a <= OFS_DELAY_THREE) begin
          r = {1'b1, IX_DLY1 + (a - OFS_DELAY_ONE)};
        end
      end
    endcase
    return r;
  endfunction

  assign bank = regs_ff[IX_GC1][BANK_BIT];
  assign {hit, idx} = decode(i_acc_addr, bank);
  assign wr_hit = i_acc_en && i_acc_wr && hit;

  // ****************
  // Register writes
  // ****************
  // Only the slot picked by the bank is written; the other copy keeps its value
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= RST_VAL[i];
      end
    end else if (wr_hit) begin
      if (idx == IX_GC1) begin
        // Reserved read-as-zero bits never store a one
        regs_ff[idx] <= i_acc_wdata & ~GC1_RO_ZERO;
      end else begin
        regs_ff[idx] <= i_acc_wdata;
      end
    end
  end

  // ****************
  // Watchdog toggle check
  // ****************
  // Sticky until reset: a write that fails to invert the toggle bit is a host fault
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      failsafe_ff <= 1'b0;
    end else if (wr_hit && idx == IX_GC1 &&
                 i_acc_wdata[WD_TOGGLE_BIT] == regs_ff[IX_GC1][WD_TOGGLE_BIT]) begin
      failsafe_ff <= 1'b1;
    end
  end

  // ****************
  // Read path
  // ****************
  // Unmapped offsets read zero and flag an error for one cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      rvalid_ff <= i_acc_en && !i_acc_wr;
      err_ff <= i_acc_en && !hit;
      if (i_acc_en && !i_acc_wr) begin
        rdata_ff <= hit ? regs_ff[idx] : 16'h0000;
      end
    end
  end

  assign o_acc_rdata = rdata_ff;
  assign o_acc_rvalid = rvalid_ff;
  assign o_acc_err = err_ff;

  // ****************
  // Settings out
  // ****************
  assign o_bank_sel = bank;
  assign o_failsafe = failsafe_ff;
  assign o_gen_ctrl1 = regs_ff[IX_GC1];
  assign o_gen_ctrl2 = regs_ff[IX_GC2];
  assign o_hb_mode = regs_ff[IX_HBM];
  assign o_pwm_setup = regs_ff[IX_PWMS];
  assign o_ccb_active = regs_ff[IX_CCB_ACT];
  assign o_ccb_freewheel = regs_ff[IX_CCB_FW];
  assign o_chg_active = regs_ff[IX_CHG_ACT];
  assign o_chg_freewheel = regs_ff[IX_CHG_FW];
  assign o_max_active = regs_ff[IX_MAX_ACT];
  assign o_max_freewheel = regs_ff[IX_MAX_FW];
  assign o_post_dischg_cur = regs_ff[IX_MAX_ACT];

  // ****************
  // Active / freewheel role per bridge
  // ****************
  // With adaptive control off both MOSFETs use the active copies
  assign adaptive_gate_control_cfg = regs_ff[IX_GC2][AGC_LSB +: 2];
  for (genvar h = 0; h < NUM_HB; h++) begin : g_role
    assign o_hs_uses_fw[h] = (adaptive_gate_control_cfg != AGC_OFF) && !i_hs_switching[h];
    assign o_ls_uses_fw[h] = (adaptive_gate_control_cfg != AGC_OFF) && i_hs_switching[h];
  end
endmodule
`default_nettype wire

// ---- bench/gdr_host.sv ----
// Host model issuing one register access at a time
`default_nettype none
module gdr_host (
  // Clock
  input wire logic i_ref_clk,
  // Access port toward the register file
  output logic o_en,
  output logic o_wr,
  output logic [gdr_pkg::ADDR_W-1:0] o_addr,
  output logic [gdr_pkg::DATA_W-1:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wd_ff;
  logic [15:0] sent;
  initial begin
    o_en = 1'b0;
    o_wr = 1'b0;
    o_addr = 5'h1f;
    o_wdata = 16'h0;
    wd_ff = 1'b0;
  end
  // Keep only for a deliberate fail-safe trip
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, input logic keep);
    @(posedge i_ref_clk);
    sent = d;
    if (w && a == 5'h00) begin
      sent[0] = keep ? wd_ff : ~wd_ff;
      wd_ff = sent[0];
    end
    o_en <= 1'b1;
    o_wr <= w;
    o_addr <= a;
    o_wdata <= sent;
    @(posedge i_ref_clk);
    o_en <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~sent;
    #1;
  endtask
endmodule
`default_nettype wire

// ---- bench/gdr_regbank_asserts.sv ----
// Port checks of the banked register file
`default_nettype none
module gdr_regbank_asserts (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Watched ports
  input wire logic i_acc_en,
  input wire logic i_acc_wr,
  input wire logic [4:0] i_acc_addr,
  input wire logic [15:0] i_acc_wdata,
  input wire logic o_acc_rvalid,
  input wire logic o_acc_err,
  input wire logic o_bank_sel,
  input wire logic o_failsafe,
  input wire logic [15:0] o_gen_ctrl1,
  input wire logic [15:0] o_max_active,
  input wire logic [15:0] o_post_dischg_cur
);
  import gdr_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  sequence s_gc1_wr;
    i_acc_en && i_acc_wr && i_acc_addr == OFS_GEN_CTRL1;
  endsequence
  sequence s_max_wr;
    i_acc_en && i_acc_wr && i_acc_addr == OFS_MAX_CUR;
  endsequence
  AST_RD_ANSWER: assert property (i_acc_en && !i_acc_wr |=> o_acc_rvalid) else $error("read unanswered");
  AST_HIGH_ERR: assert property (i_acc_en && i_acc_addr > OFS_DELAY_THREE |=> o_acc_err) else $error("no err");
  AST_PWM_BANK: assert property (i_acc_en && i_acc_addr == OFS_PWM_SETUP |=> o_acc_err == $past(o_bank_sel))
    else $error("pwm setup decode");
  AST_BANK_BIT: assert property (o_bank_sel == o_gen_ctrl1[BANK_BIT]) else $error("bank select");
  AST_POST_DIS: assert property (o_post_dischg_cur == o_max_active) else $error("post discharge");
  AST_GC1_STORE: assert property (s_gc1_wr |=> o_gen_ctrl1 == ($past(i_acc_wdata) & ~GC1_RO_ZERO))
    else $error("gc1 store");
  AST_FAILSAFE: assert property (s_gc1_wr ##0 i_acc_wdata[0] == o_gen_ctrl1[0] |=> o_failsafe [*3])
    else $error("failsafe");
  AST_MAX_ACT: assert property (s_max_wr ##0 !o_bank_sel |=> o_max_active == $past(i_acc_wdata))
    else $error("max active");
  AST_MAX_KEEP: assert property (s_max_wr ##0 o_bank_sel |=> $stable(o_max_active)) else $error("max kept");
endmodule
bind gdr_regbank gdr_regbank_asserts gdr_regbank_asserts_inst (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
  .i_acc_en(i_acc_en), .i_acc_wr(i_acc_wr), .i_acc_addr(i_acc_addr), .i_acc_wdata(i_acc_wdata),
  .o_acc_rvalid(o_acc_rvalid), .o_acc_err(o_acc_err), .o_bank_sel(o_bank_sel), .o_failsafe(o_failsafe),
  .o_gen_ctrl1(o_gen_ctrl1), .o_max_active(o_max_active), .o_post_dischg_cur(o_post_dischg_cur));
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the banked register file
`default_nettype none
module tb;
  import gdr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk;
  logic i_srst;
  logic en, wr, rv, er, fs, bank;
  logic [3:0] sw, hfw, lfw;
  logic [4:0] ad;
  logic [15:0] wd, rd, pdc, g2, hbm, mfw;
  logic [15:0] mdl [2][17];
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  localparam logic [15:0] RV [2][17] = '{
    '{16'h0026, 16'h4180, 16'h0249, 16'h0, 16'h0, 16'h4924, 16'h0, 16'h6420, 16'h0, 16'hc000, 16'h0044,
      16'h18c6, 16'h1ce7, 16'h4900, 16'h0a0a, 16'h0a0a, 16'h0a0a},
    '{16'h0026, 16'h4180, 16'h0249, 16'h0, 16'h0, 16'h4924, 16'h0, 16'h0, 16'h0, 16'hc000, 16'h18c6,
      16'h18c6, 16'h318c, 16'h4900, 16'h0a0a, 16'h0a0a, 16'h0a0a}};
  gdr_host host_inst (.i_ref_clk(i_ref_clk), .o_en(en), .o_wr(wr), .o_addr(ad), .o_wdata(wd));
  gdr_regbank gdr_regbank_inst (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_acc_en(en), .i_acc_wr(wr),
    .i_acc_addr(ad), .i_acc_wdata(wd), .o_acc_rdata(rd), .o_acc_rvalid(rv), .o_acc_err(er),
    .i_hs_switching(sw), .o_bank_sel(), .o_failsafe(fs), .o_gen_ctrl1(), .o_gen_ctrl2(g2), .o_hb_mode(hbm),
    .o_pwm_setup(), .o_ccb_active(), .o_ccb_freewheel(), .o_chg_active(), .o_chg_freewheel(),
    .o_max_active(), .o_max_freewheel(mfw), .o_post_dischg_cur(pdc), .o_hs_uses_fw(hfw), .o_ls_uses_fw(lfw));
  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Every offset read back, one past the map included
  task automatic sweep();
    logic m;
    for (int a = 0; a < 18; a++) begin
      m = a < 17 && a != 3 && !(a == 7 && bank);
      host_inst.acc(1'b0, a[4:0], 16'h0, 1'b0);
      chk("err", {15'h0, !m}, {15'h0, er});
      chk("rvalid", 16'h1, {15'h0, rv});
      chk("rdata", m ? mdl[bank][a] : 16'h0, rd);
    end
  endtask
  task automatic put(input logic [4:0] a, input logic [15:0] d, input logic keep);
    host_inst.acc(1'b1, a, d, keep);
    d = host_inst.sent;
    if (a == 5'h0) d = d & ~GC1_RO_ZERO;
    if (a < 17 && a != 3 && !(a == 7 && bank)) begin
      if (a inside {5'h05, 5'h07, [5'h0a:5'h0d]}) mdl[bank][a] = d;
      else begin
        mdl[0][a] = d;
        mdl[1][a] = d;
      end
    end
    bank = mdl[0][0][BANK_BIT];
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    i_srst = 1'b1;
    sw = 4'h0;
    mdl = RV;
    bank = 1'b0;
    void'($urandom(52));
    repeat (3) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    sweep();
    put(5'h0, 16'h0226, 1'b0);
    sweep();
    repeat (80) begin
      sw <= 4'($urandom);
      put(5'($urandom_range(0, 17)), 16'($urandom), 1'b0);
    end
    sweep();
    chk("postdis", mdl[0][13], pdc);
    chk("general_control_two", mdl[0][1], g2);
    chk("half_bridge_mode_sel", mdl[0][6], hbm);
    chk("maxfw", mdl[1][13], mfw);
    chk("hsfw", {12'h0, mdl[0][1][12:11] == 2'h0 ? 4'h0 : ~sw}, {12'h0, hfw});
    chk("lsfw", {12'h0, mdl[0][1][12:11] == 2'h0 ? 4'h0 : sw}, {12'h0, lfw});
    chk("failsafe", 16'h0, {15'h0, fs});
    put(5'h0, 16'h0, 1'b1);
    chk("failsafe", 16'h1, {15'h0, fs});
    close_out();
  end
endmodule
`default_nettype wire
